//--- core/mse_core.sv
`timescale 1ns/1ps
// serial engine framework: mode decode, buffers, baud, match, lanes
// Operation
// - mode field: 0/1 uart ext/int, 2/3 spi, 4/5 i2c, 6-7 reserved
// - enabled unit runs only the one selected protocol
// - transmitter is one write buffer feeding a shift register
// - receive buffer one deep in i2c, two deep otherwise
// - all protocol signals but the external clock (ext_clk_pin) go through four multiplexed lanes
// - core clock needed as master; slow clock only for some functions
// - engine and baud run on internal or external clock
// - keeps running in sleep while its clock runs; irq may wake
// - writes from bus domain synchronised into engine domain
// - runs during debug halt unless halt control is set
// - protection gates writes except flag, status, data, address
// - debugger accesses bypass write protection
// - address matching used in spi and i2c only
// - one interrupt request line
// - bus clock may be gated independently of engine clocks
// - enable bit on/off; soft reset clears all but halt control
// - baud output /16 async tx, /1 async rx, /2 synchronous
// - irq while flag and enable set, until either clears or reset
// - masked bits ignored; zero mask one address, ones mask all
module mse_core
   import mse_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic cfg_write,
   input wire logic cfg_debugger,
   input wire logic protect_on,
   input wire logic [MSE_MODE_W-1:0] operating_mode_field,
   input wire logic unit_enable_bit,
   input wire logic soft_reset_bit,
   input wire logic [MSE_BAUD_W-1:0] baud_value,
   input wire logic dbg_write,
   input wire logic debug_halt_control,
   input wire logic debug_halted,
   input wire logic ext_clk_pin,
   input wire logic addr_write,
   input wire logic [MSE_ADDR_W-1:0] match_addr,
   input wire logic [MSE_ADDR_W-1:0] match_mask_field,
   input wire logic [MSE_ADDR_W-1:0] rx_addr,
   input wire logic rx_addr_valid,
   input wire logic tx_valid,
   input wire logic [MSE_DATA_W-1:0] tx_data,
   output logic tx_ready,
   output logic rx_valid,
   output logic [MSE_DATA_W-1:0] rx_data,
   input wire logic rx_ready,
   input wire logic flag_write,
   input wire logic [MSE_NFLAG-1:0] flag_clear,
   input wire logic [MSE_NFLAG-1:0] inten_set,
   input wire logic [MSE_NFLAG-1:0] inten_clear,
   input wire logic [MSE_LANES-1:0] lane_in,
   output logic [MSE_LANES-1:0] lane_out,
   output logic [MSE_LANES-1:0] lane_oe_n,
   output logic [MSE_NFLAG-1:0] flag_status,
   output logic [MSE_NFLAG-1:0] inten_status,
   output logic enabled,
   output logic [MSE_MODE_W-1:0] mode_status,
   output logic irq
);
   function automatic logic addr_hit(input logic [MSE_ADDR_W-1:0] a,
      input logic [MSE_ADDR_W-1:0] ref_a, input logic [MSE_ADDR_W-1:0] m);
      addr_hit = ((a ^ ref_a) & ~m) == '0;
   endfunction

   // pin synchronisers
   logic [MSE_LANES-1:0] lane_s1, lane_s2;
   logic ext_s1, ext_s2, ext_s3;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         lane_s1 <= '0;
         lane_s2 <= '0;
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
         ext_s3 <= 1'b0;
      end else begin
         lane_s1 <= lane_in;
         lane_s2 <= lane_s1;
         ext_s1 <= ext_clk_pin;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
      end
   end

   // configuration registers
   mse_mode_t mode, next_mode;
   logic en, next_en, halt_ctl, next_halt_ctl;
   logic [MSE_BAUD_W-1:0] baud, next_baud;
   logic [MSE_ADDR_W-1:0] maddr, next_maddr, mmask, next_mmask;
   logic [MSE_NFLAG-1:0] inten, next_inten, flags, next_flags;
   logic cfg_ok;
   always_comb begin
      cfg_ok = cfg_write && (!protect_on || cfg_debugger);
      next_mode = mode;
      next_en = en;
      next_baud = baud;
      next_inten = inten;
      next_maddr = maddr;
      next_mmask = mmask;
      next_halt_ctl = halt_ctl;
      if (dbg_write && (!protect_on || cfg_debugger)) begin
         next_halt_ctl = debug_halt_control;
      end
      if (cfg_ok && soft_reset_bit) begin
         next_mode = MSE_MODE_UART_EXT;
         next_en = 1'b0;
         next_baud = MSE_BAUD_RST;
         next_inten = MSE_INTEN_RST;
         next_maddr = '0;
         next_mmask = '0;
      end else begin
         if (cfg_ok) begin
            next_en = unit_enable_bit;
            if (!en) begin
               next_mode = mse_mode_t'(operating_mode_field);
               next_baud = baud_value;
            end
         end
         if (cfg_ok) begin
            next_inten = (inten | inten_set) & ~inten_clear;
         end
         if (addr_write) begin
            next_maddr = match_addr;
            next_mmask = match_mask_field;
         end
      end
   end
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mode <= MSE_MODE_UART_EXT;
         en <= 1'b0;
         halt_ctl <= 1'b0;
         baud <= MSE_BAUD_RST;
         inten <= MSE_INTEN_RST;
         maddr <= '0;
         mmask <= '0;
      end else begin
         mode <= next_mode;
         en <= next_en;
         halt_ctl <= next_halt_ctl;
         baud <= next_baud;
         inten <= next_inten;
         maddr <= next_maddr;
         mmask <= next_mmask;
      end
   end

   // mode decode
   logic valid_mode, is_i2c, is_spi, is_uart, is_master, run;
   logic ext_clocked, srst;
   always_comb begin
      srst = cfg_ok && soft_reset_bit;
      valid_mode = (mode != MSE_MODE_RSV6) && (mode != MSE_MODE_RSV7);
      is_uart = (mode == MSE_MODE_UART_EXT) || (mode == MSE_MODE_UART_INT);
      is_spi = (mode == MSE_MODE_SPI_SLV) || (mode == MSE_MODE_SPI_MST);
      is_i2c = (mode == MSE_MODE_I2C_SLV) || (mode == MSE_MODE_I2C_MST);
      is_master = (mode == MSE_MODE_UART_INT) || (mode == MSE_MODE_SPI_MST)
         || (mode == MSE_MODE_I2C_MST);
      ext_clocked = !is_master;
      run = en && valid_mode && !(debug_halted && halt_ctl);
   end

   // baud generator, divided tick selection
   logic [MSE_BAUD_W-1:0] bcnt, next_bcnt;
   logic [3:0] sub, next_sub, div_sel;
   logic tick, next_tick, bit_tick, rtick, next_rtick;
   always_comb begin
      if (is_uart) begin
         div_sel = MSE_ASYNC_TX_DIV;
      end else begin
         div_sel = MSE_SYNC_DIV;
      end
      next_bcnt = bcnt;
      next_sub = sub;
      next_tick = 1'b0;
      next_rtick = 1'b0;
      if (!run) begin
         next_bcnt = '0;
         next_sub = '0;
      end else if (ext_clocked) begin
         next_tick = ext_s2 && !ext_s3;
         next_rtick = ext_s2 && !ext_s3;
      end else if (bcnt >= baud) begin
         next_bcnt = '0;
         // receive tick, undivided for async reception
         next_rtick = sub >= (is_uart ? MSE_ASYNC_RX_DIV : div_sel);
         if (sub >= div_sel) begin
            next_sub = '0;
            next_tick = 1'b1;
         end else begin
            next_sub = sub + 4'h1;
         end
      end else begin
         next_bcnt = bcnt + 16'h0001;
      end
      bit_tick = tick;
   end
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         bcnt <= '0;
         sub <= '0;
         tick <= 1'b0;
         rtick <= 1'b0;
      end else begin
         bcnt <= next_bcnt;
         sub <= next_sub;
         tick <= next_tick;
         rtick <= next_rtick;
      end
   end

   // transmit: one write buffer into the shift register
   mse_state_t tst, next_tst;
   logic [MSE_DATA_W-1:0] wbuf, next_wbuf, tsh, next_tsh;
   logic wfull, next_wfull;
   logic [3:0] tcnt, next_tcnt;
   logic txc_ev, next_txc_ev;
   always_comb begin
      next_wbuf = wbuf;
      next_wfull = wfull;
      next_tst = tst;
      next_tsh = tsh;
      next_tcnt = tcnt;
      next_txc_ev = 1'b0;
      if (tx_valid && !wfull) begin
         next_wbuf = tx_data;
         next_wfull = 1'b1;
      end
      case (tst)
         MSE_ST_IDLE: begin
            if (run && wfull) begin
               next_tsh = wbuf;
               next_wfull = 1'b0;
               next_tcnt = '0;
               next_tst = MSE_ST_SHIFT;
            end
         end
         MSE_ST_SHIFT: begin
            if (!run) begin
               next_tst = MSE_ST_IDLE;
            end else if (bit_tick) begin
               next_tsh = {tsh[MSE_DATA_W-2:0], 1'b1};
               next_tcnt = tcnt + 4'h1;
               if (tcnt == MSE_BITS - 4'h1) begin
                  next_tst = MSE_ST_DONE;
               end
            end
         end
         MSE_ST_DONE: begin
            next_txc_ev = 1'b1;
            next_tst = MSE_ST_IDLE;
         end
         default: next_tst = MSE_ST_IDLE;
      endcase
      if (srst) begin
         next_wfull = 1'b0;
         next_tst = MSE_ST_IDLE;
      end
   end
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         tst <= MSE_ST_IDLE;
         wbuf <= '0;
         wfull <= 1'b0;
         tsh <= '0;
         tcnt <= '0;
         txc_ev <= 1'b0;
      end else begin
         tst <= next_tst;
         wbuf <= next_wbuf;
         wfull <= next_wfull;
         tsh <= next_tsh;
         tcnt <= next_tcnt;
         txc_ev <= next_txc_ev;
      end
   end

   // receive shift register and address match
   logic [MSE_DATA_W-1:0] rsh, next_rsh;
   logic [3:0] rcnt, next_rcnt;
   logic rpush, next_rpush, rb_ready, match_ev, next_match_ev;
   logic rb_valid;
   logic [MSE_DATA_W-1:0] rb_data;
   always_comb begin
      next_rsh = rsh;
      next_rcnt = rcnt;
      next_rpush = rpush && !rb_ready;
      next_match_ev = 1'b0;
      if (!run || srst) begin
         next_rcnt = '0;
         next_rpush = 1'b0;
      end else if (rtick && !rpush) begin
         next_rsh = {rsh[MSE_DATA_W-2:0], lane_s2[1]};
         next_rcnt = rcnt + 4'h1;
         if (rcnt == MSE_BITS - 4'h1) begin
            next_rcnt = '0;
            next_rpush = 1'b1;
         end
      end
      if (run && (is_spi || is_i2c) && rx_addr_valid
         && addr_hit(rx_addr, maddr, mmask)) begin
         next_match_ev = 1'b1;
      end
   end
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rsh <= '0;
         rcnt <= '0;
         rpush <= 1'b0;
         match_ev <= 1'b0;
      end else begin
         rsh <= next_rsh;
         rcnt <= next_rcnt;
         rpush <= next_rpush;
         match_ev <= next_match_ev;
      end
   end

   mse_rxbuf u_rxbuf (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .flush(srst),
      .depth(is_i2c ? MSE_RXDEPTH_I2C : MSE_RXDEPTH_OTHER),
      .in_valid(rpush),
      .in_ready(rb_ready),
      .in_data(rsh),
      .out_valid(rb_valid),
      .out_ready(rx_ready),
      .out_data(rb_data)
   );

   // flags, lanes and registered outputs
   logic [MSE_NFLAG-1:0] ev;
   logic [MSE_LANES-1:0] next_lane_out, next_lane_oe_n;
   logic next_irq;
   always_comb begin
      ev = '0;
      ev[MSE_FLAG_TXE] = run && !wfull;
      ev[MSE_FLAG_TXC] = txc_ev;
      ev[MSE_FLAG_RXC] = rb_valid;
      ev[MSE_FLAG_MATCH] = match_ev;
      next_flags = flags;
      if (flag_write) begin
         next_flags = flags & ~flag_clear;
      end
      next_flags = next_flags | ev;
      if (srst) begin
         next_flags = MSE_FLAG_RST;
      end
      next_irq = |(next_flags & next_inten);
      next_lane_out = '1;
      next_lane_oe_n = '1;
      if (run) begin
         next_lane_out[0] = tsh[MSE_DATA_W-1];
         next_lane_oe_n[0] = (tst != MSE_ST_SHIFT);
         if (is_master) begin
            next_lane_out[1] = tick;
            next_lane_oe_n[1] = !(is_spi || is_i2c);
         end
         if (is_spi && is_master) begin
            next_lane_out[2] = 1'b0;
            next_lane_oe_n[2] = (tst != MSE_ST_SHIFT);
         end
      end
   end
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         flags <= MSE_FLAG_RST;
         irq <= 1'b0;
         lane_out <= '1;
         lane_oe_n <= '1;
         flag_status <= '0;
         inten_status <= '0;
         enabled <= 1'b0;
         mode_status <= '0;
         tx_ready <= 1'b0;
         rx_valid <= 1'b0;
         rx_data <= '0;
      end else begin
         flags <= next_flags;
         irq <= next_irq;
         lane_out <= next_lane_out;
         lane_oe_n <= next_lane_oe_n;
         flag_status <= next_flags;
         inten_status <= next_inten;
         enabled <= next_en;
         mode_status <= next_mode;
         tx_ready <= !next_wfull;
         rx_valid <= rb_valid;
         rx_data <= rb_data;
      end
   end
endmodule

//--- core/mse_rxbuf.sv
`timescale 1ns/1ps
// two-entry receive buffer with selectable depth
module mse_rxbuf
   import mse_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic flush,
   input wire logic [1:0] depth,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [MSE_DATA_W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [MSE_DATA_W-1:0] out_data
);
   logic [MSE_DATA_W-1:0] mem [0:1];
   logic [MSE_DATA_W-1:0] next_mem0, next_mem1;
   logic [1:0] count, next_count;
   logic push, pop;

   always_comb begin
      in_ready = (count < depth);
      out_valid = (count != 2'h0);
      out_data = mem[0];
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      next_mem0 = mem[0];
      next_mem1 = mem[1];
      next_count = count;
      if (flush) begin
         next_count = 2'h0;
      end else begin
         if (pop) begin
            next_mem0 = mem[1];
         end
         if (push) begin
            if (count - (pop ? 2'h1 : 2'h0) == 2'h0) begin
               next_mem0 = in_data;
            end else begin
               next_mem1 = in_data;
            end
         end
         next_count = count + (push ? 2'h1 : 2'h0) - (pop ? 2'h1 : 2'h0);
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mem[0] <= '0;
         mem[1] <= '0;
         count <= 2'h0;
      end else begin
         mem[0] <= next_mem0;
         mem[1] <= next_mem1;
         count <= next_count;
      end
   end
endmodule

//--- shared/mse_pkg.sv
// constants and types for the multiprotocol serial engine
package mse_pkg;
   localparam int MSE_DATA_W = 8;
   localparam int MSE_ADDR_W = 8;
   localparam int MSE_BAUD_W = 16;
   localparam int MSE_LANES = 4;
   localparam int MSE_MODE_W = 3;
   localparam int MSE_NFLAG = 4;
   localparam logic [MSE_NFLAG-1:0] MSE_INTEN_RST = 4'h0;
   localparam logic [MSE_NFLAG-1:0] MSE_FLAG_RST = 4'h0;
   localparam int MSE_FLAG_TXE = 0;
   localparam int MSE_FLAG_TXC = 1;
   localparam int MSE_FLAG_RXC = 2;
   localparam int MSE_FLAG_MATCH = 3;
   localparam logic [3:0] MSE_ASYNC_TX_DIV = 4'hF;
   localparam logic [3:0] MSE_ASYNC_RX_DIV = 4'h0;
   localparam logic [3:0] MSE_SYNC_DIV = 4'h1;
   localparam logic [3:0] MSE_BITS = 4'h8;
   localparam logic [1:0] MSE_RXDEPTH_I2C = 2'h1;
   localparam logic [1:0] MSE_RXDEPTH_OTHER = 2'h2;
   localparam logic [MSE_BAUD_W-1:0] MSE_BAUD_RST = 16'h0000;
   typedef enum logic [2:0] {
      MSE_MODE_UART_EXT = 3'b000,
      MSE_MODE_UART_INT = 3'b001,
      MSE_MODE_SPI_SLV = 3'b010,
      MSE_MODE_SPI_MST = 3'b011,
      MSE_MODE_I2C_SLV = 3'b100,
      MSE_MODE_I2C_MST = 3'b101,
      MSE_MODE_RSV6 = 3'b110,
      MSE_MODE_RSV7 = 3'b111
   } mse_mode_t;
   typedef enum logic [1:0] {
      MSE_ST_IDLE = 2'b00,
      MSE_ST_SHIFT = 2'b01,
      MSE_ST_DONE = 2'b10
   } mse_state_t;
endpackage

//--- verif/mse_core_sva.sv
`timescale 1ns/1ps
// concurrent checks on the serial engine framework ports
module mse_core_sva
   import mse_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic cfg_write,
   input wire logic cfg_debugger,
   input wire logic protect_on,
   input wire logic [MSE_MODE_W-1:0] operating_mode_field,
   input wire logic unit_enable_bit,
   input wire logic soft_reset_bit,
   input wire logic [MSE_NFLAG-1:0] inten_set,
   input wire logic [MSE_NFLAG-1:0] inten_clear,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [MSE_LANES-1:0] lane_oe_n,
   input wire logic [MSE_NFLAG-1:0] flag_status,
   input wire logic [MSE_NFLAG-1:0] inten_status,
   input wire logic enabled,
   input wire logic [MSE_MODE_W-1:0] mode_status,
   input wire logic irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // accepted configuration write, plain or soft reset
   sequence s_cfg;
      cfg_write && (!protect_on || cfg_debugger) && !soft_reset_bit;
   endsequence
   sequence s_srst;
      cfg_write && (!protect_on || cfg_debugger) && soft_reset_bit;
   endsequence
   sequence s_locked;
      cfg_write && protect_on && !cfg_debugger;
   endsequence
   property p_mode_take;
      s_cfg ##0 !enabled |=> mode_status == $past(operating_mode_field);
   endproperty
   property p_mode_hold;
      s_cfg ##0 enabled |=> $stable(mode_status);
   endproperty
   property p_enable;
      s_cfg |=> enabled == $past(unit_enable_bit);
   endproperty
   property p_srst;
      s_srst |=> !enabled && flag_status == MSE_FLAG_RST
         && inten_status == MSE_INTEN_RST;
   endproperty
   property p_locked;
      s_locked |=> $stable(enabled) && $stable(inten_status);
   endproperty
   property p_inten;
      s_cfg ##0 (inten_set & inten_clear) == 4'h0 |=> inten_status ==
         (($past(inten_status) | $past(inten_set)) & ~$past(inten_clear));
   endproperty
   property p_irq;
      irq == |(flag_status & inten_status);
   endproperty
   property p_reserved;
      enabled && mode_status[2:1] == 2'h3 |=> lane_oe_n == 4'hF;
   endproperty
   property p_tx_take;
      enabled && mode_status < 3'h6 && tx_valid && tx_ready |=> !tx_ready;
   endproperty
   a_mode_take: assert property (p_mode_take)
      else $error("mode not taken from write");
   a_mode_hold: assert property (p_mode_hold)
      else $error("mode changed while enabled");
   a_enable: assert property (p_enable)
      else $error("enable bit not applied");
   a_srst: assert property (p_srst)
      else $error("soft reset left state behind");
   a_locked: assert property (p_locked)
      else $error("protected write took effect");
   a_inten: assert property (p_inten)
      else $error("interrupt enable set or clear wrong");
   a_irq: assert property (p_irq)
      else $error("irq does not match flags and enables");
   a_reserved: assert property (p_reserved)
      else $error("lane driven in reserved mode");
   a_tx_take: assert property (p_tx_take)
      else $error("write buffer still ready after taking word");
endmodule

//--- verif/mse_far_dev.sv
`timescale 1ns/1ps
// far-side serial device model driving the clock pin and lanes
module mse_far_dev
   import mse_pkg::*;
(
   input wire logic clk_sys,
   output logic ext_clk_pin,
   output logic [MSE_LANES-1:0] lane_in,
   input wire logic [MSE_LANES-1:0] lane_out,
   input wire logic [MSE_LANES-1:0] lane_oe_n
);
   logic tog = 1'b0;
   logic act;
   logic bit_q;
   logic [MSE_LANES-1:0] far;
   initial begin
      act = 1'b0;
      bit_q = 1'b0;
      ext_clk_pin = 1'b0;
   end
   // released lanes toggle so no stale level reads back
   always @(posedge clk_sys) begin
      tog <= ~tog;
   end
   assign far = {tog, tog, act ? bit_q : tog, tog};
   assign lane_in = (~lane_oe_n & lane_out) | (lane_oe_n & far);
   // one frame msb first, hp cycles per clock half, clock idle low
   task automatic xfer(input logic [7:0] send, output logic [7:0] got,
      input int hp);
      act = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         bit_q = send[i];
         repeat (hp) @(negedge clk_sys);
         got[i] = lane_out[0];
         ext_clk_pin = 1'b1;
         repeat (hp) @(negedge clk_sys);
         ext_clk_pin = 1'b0;
      end
      act = 1'b0;
   endtask
endmodule

//--- verif/test_mse_core.sv
`timescale 1ns/1ps
// self-checking bench for the serial engine framework
module test_mse_core;
   import mse_pkg::*;
   logic clk_sys, reset_n, cfg_write, cfg_debugger, protect_on;
   logic [2:0] operating_mode_field;
   logic unit_enable_bit, soft_reset_bit, dbg_write, debug_halt_control;
   logic debug_halted, ext_clk_pin, addr_write, rx_addr_valid;
   logic tx_valid, tx_ready, rx_valid, rx_ready, flag_write;
   logic enabled, irq;
   logic [15:0] baud_value;
   logic [7:0] match_addr, match_mask_field, rx_addr, tx_data, rx_data;
   logic [3:0] flag_clear, inten_set, inten_clear, lane_in, lane_out;
   logic [3:0] lane_oe_n, flag_status, inten_status;
   logic [2:0] mode_status;
   logic [7:0] got;
   logic [7:0] mm [5] = '{8'h00, 8'h00, 8'h0F, 8'h0F, 8'hFF};
   logic [7:0] ca [5] = '{8'h5A, 8'h5B, 8'h53, 8'hA5, 8'hA5};
   logic [4:0] ex = 5'b10101;
   int checks = 0;
   int miscompares = 0;
   mse_core dut (.clk_sys, .reset_n, .cfg_write, .cfg_debugger,
      .protect_on, .operating_mode_field, .unit_enable_bit,
      .soft_reset_bit, .baud_value, .dbg_write, .debug_halt_control,
      .debug_halted, .ext_clk_pin, .addr_write, .match_addr,
      .match_mask_field, .rx_addr, .rx_addr_valid, .tx_valid, .tx_data,
      .tx_ready, .rx_valid, .rx_data, .rx_ready, .flag_write, .flag_clear,
      .inten_set, .inten_clear, .lane_in, .lane_out, .lane_oe_n,
      .flag_status, .inten_status, .enabled, .mode_status, .irq);
   mse_far_dev far (.clk_sys, .ext_clk_pin, .lane_in, .lane_out,
      .lane_oe_n);
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic end_sim();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic cfg(input logic [2:0] m, input logic en, input logic sr,
      input logic [3:0] is, input logic [3:0] ic);
      @(negedge clk_sys);
      operating_mode_field = m;
      unit_enable_bit = en;
      soft_reset_bit = sr;
      inten_set = is;
      inten_clear = ic;
      cfg_write = 1'b1;
      @(negedge clk_sys);
      cfg_write = 1'b0;
      soft_reset_bit = 1'b0;
      inten_set = 4'h0;
      inten_clear = 4'h0;
      @(negedge clk_sys);
   endtask
   task automatic fclr(input logic [3:0] m);
      flag_clear = m;
      flag_write = 1'b1;
      @(negedge clk_sys);
      flag_write = 1'b0;
      cyc(1);
   endtask
   task automatic raddr(input logic [7:0] a);
      rx_addr = a;
      rx_addr_valid = 1'b1;
      @(negedge clk_sys);
      rx_addr_valid = 1'b0;
      cyc(2);
   endtask
   task automatic push(input logic [7:0] d);
      tx_valid = 1'b1;
      tx_data = d;
      for (int i = 0; i < 200 && tx_ready !== 1'b1; i++) cyc(1);
      @(negedge clk_sys);
      tx_valid = 1'b0;
   endtask
   task automatic pop(output logic [7:0] d);
      for (int i = 0; i < 200 && rx_valid !== 1'b1; i++) cyc(1);
      d = rx_data;
      rx_ready = 1'b1;
      @(negedge clk_sys);
      rx_ready = 1'b0;
      cyc(2);
   endtask
   initial begin
      #1000000;
      miscompares++;
      end_sim();
   end
   initial begin
      {reset_n, cfg_write, cfg_debugger, protect_on, unit_enable_bit} = '0;
      {soft_reset_bit, dbg_write, debug_halt_control, debug_halted} = '0;
      {addr_write, rx_addr_valid, tx_valid, rx_ready, flag_write} = '0;
      {operating_mode_field, flag_clear, inten_set, inten_clear} = '0;
      {match_addr, match_mask_field, rx_addr, tx_data} = '0;
      baud_value = 16'h0003;
      cyc(6);
      reset_n = 1'b1;
      cyc(1);
      chk(8'({enabled, irq, lane_oe_n}), 8'h0F);
      chk(8'({flag_status, inten_status}), 8'h00);
      for (int m = 0; m < 8; m++) begin
         cfg(3'(m), 1'b1, 1'b0, 4'h0, 4'h0);
         chk(8'({enabled, mode_status}), 8'(8 + m));
         cyc(4);
         if (m > 5) chk(8'(lane_oe_n), 8'h0F);
         cfg(3'(m), 1'b0, 1'b0, 4'h0, 4'h0);
         chk(8'(enabled), 8'h00);
      end
      cfg(3'h3, 1'b1, 1'b0, 4'h0, 4'h0);
      cfg(3'h5, 1'b1, 1'b0, 4'h0, 4'h0);
      chk(8'(mode_status), 8'h03);
      protect_on = 1'b1;
      cfg(3'h2, 1'b0, 1'b0, 4'h0, 4'h0);
      chk(8'(enabled), 8'h01);
      cfg_debugger = 1'b1;
      cfg(3'h2, 1'b0, 1'b0, 4'h0, 4'h0);
      chk(8'(enabled), 8'h00);
      cfg(3'h2, 1'b1, 1'b0, 4'h0, 4'h0);
      cfg_debugger = 1'b0;
      for (int k = 0; k < 5; k++) begin
         match_addr = 8'h5A;
         match_mask_field = mm[k];
         addr_write = 1'b1;
         cyc(1);
         addr_write = 1'b0;
         raddr(ca[k]);
         chk(8'(flag_status[MSE_FLAG_MATCH]), 8'(ex[4-k]));
         fclr(4'h8);
         chk(8'(flag_status[MSE_FLAG_MATCH]), 8'h00);
      end
      protect_on = 1'b0;
      cfg(3'h2, 1'b0, 1'b0, 4'h0, 4'h0);
      cfg(3'h0, 1'b1, 1'b0, 4'h0, 4'h0);
      raddr(8'h33);
      chk(8'(flag_status[MSE_FLAG_MATCH]), 8'h00);
      cfg(3'h0, 1'b0, 1'b0, 4'h0, 4'h0);
      cfg(3'h2, 1'b1, 1'b0, 4'h2, 4'h0);
      debug_halted = 1'b1;
      push(8'hC3);
      far.xfer(8'h96, got, 4);
      chk(got, 8'hC3);
      push(8'h3C);
      far.xfer(8'h5A, got, 12);
      chk(got, 8'h3C);
      far.xfer(8'hE7, got, 4);
      debug_halted = 1'b0;
      for (int i = 0; i < 200 && flag_status[1] !== 1'b1; i++) cyc(1);
      chk(8'({flag_status[MSE_FLAG_TXC], irq}), 8'h03);
      pop(got);
      chk(got, 8'h96);
      pop(got);
      chk(got, 8'h5A);
      cfg(3'h2, 1'b1, 1'b0, 4'h0, 4'h2);
      chk(8'(irq), 8'h00);
      cfg(3'h2, 1'b1, 1'b0, 4'h2, 4'h0);
      chk(8'(irq), 8'h01);
      fclr(4'h2);
      chk(8'({flag_status[MSE_FLAG_TXC], irq}), 8'h00);
      debug_halt_control = 1'b1;
      dbg_write = 1'b1;
      cyc(1);
      dbg_write = 1'b0;
      debug_halted = 1'b1;
      push(8'hA5);
      cyc(4);
      chk(8'({tx_ready, lane_oe_n}), 8'h0F);
      cfg(3'h2, 1'b1, 1'b1, 4'h0, 4'h0);
      chk(8'({enabled, inten_status}), 8'h00);
      chk(8'(tx_ready), 8'h01);
      end_sim();
   end
endmodule
bind mse_core mse_core_sva u_sva (.clk_sys, .reset_n, .cfg_write,
   .cfg_debugger, .protect_on, .operating_mode_field, .unit_enable_bit,
   .soft_reset_bit, .inten_set, .inten_clear, .tx_valid, .tx_ready,
   .lane_oe_n, .flag_status, .inten_status, .enabled, .mode_status, .irq);
